// ---- shared/pllsc_defines.svh ----
`ifndef PLLSC_DEFINES_SVH
`define PLLSC_DEFINES_SVH
// ==========================================================
// Serial word and latch routing
`define PLLSC_WORD_W       24
`define PLLSC_SEL_REF      2'h0
`define PLLSC_SEL_DIV      2'h1
`define PLLSC_SEL_FUNC     2'h2
`define PLLSC_SEL_INIT     2'h3
`define PLLSC_LATCH_RST    24'h000000
// ==========================================================
// Function latch fields
`define PLLSC_CNT_RST_BIT  2
`define PLLSC_PD_REQ_BIT   3
`define PLLSC_TRISTATE_BIT 8
`define PLLSC_FL_EN_BIT    9
`define PLLSC_FL_MODE_BIT  10
`define PLLSC_TMO_LSB      11
`define PLLSC_CPI_PRI_LSB  15
`define PLLSC_CPI_SEC_LSB  18
`define PLLSC_PD_SYNC_BIT  21
// ==========================================================
// Divider latch fields
`define PLLSC_FAST_SEL_BIT 21
// ==========================================================
// Timeout table reset contents, in phase-detector cycles
`define PLLSC_TMO_BASE     16'h0003
`define PLLSC_TMO_STEP     16'h0004
// ==========================================================
// Register map (byte addresses)
`define PLLSC_ADDR_REF     8'h00
`define PLLSC_ADDR_DIV     8'h04
`define PLLSC_ADDR_FUNC    8'h08
`define PLLSC_ADDR_INIT    8'h0C
`define PLLSC_ADDR_STAT    8'h10
`define PLLSC_ADDR_LUT     8'h40
`define PLLSC_RESP_OKAY    2'h0
`define PLLSC_RESP_SLVERR  2'h2
`endif

// ---- shared/pllsc_pkg.sv ----
package pllsc_pkg;
  // ==========================================================
  // Pin group after synchronisation
  typedef struct packed {
    logic ce;
    logic le;
    logic sdata;
    logic sclk;
  } pllsc_pins_t;
  // ==========================================================
  // Status word
  typedef struct packed {
    logic       init_armed;
    logic       fast_active;
    logic       power_down;
    logic       counter_load;
    logic       pump_enable;
    logic [2:0] pump_current;
  } pllsc_stat_t;
  // ==========================================================
  // Register read states
  typedef enum logic [1:0] {RD_IDLE, RD_DATA, RD_RESP} pllsc_rd_t;
endpackage

// ---- src/pllsc_tmo_table.sv ----
`timescale 1ns/10ps
`include "pllsc_defines.svh"
module pllsc_tmo_table import pllsc_pkg::*; #(
  parameter int DW = 16,
  parameter int AW = 4
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_a_i,
  output logic      [DW-1:0] rdata_a_o,
  input  wire logic [AW-1:0] raddr_b_i,
  output logic      [DW-1:0] rdata_b_o
);
  localparam int DEPTH = 1 << AW;
  logic [DW-1:0] mem_reg  [DEPTH];
  logic [DW-1:0] mem_next [DEPTH];
  // ==========================================================
  // Default entry for a code
  function automatic logic [DW-1:0] dflt(input int i);
    return DW'(`PLLSC_TMO_BASE + `PLLSC_TMO_STEP * i);
  endfunction
  always_comb begin
    mem_next = mem_reg;
    if (we_i) begin
      mem_next[waddr_i] = wdata_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= dflt(i);
      end
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else begin
      mem_reg   <= mem_next;
      rdata_a_o <= mem_reg[raddr_a_i];
      rdata_b_o <= mem_reg[raddr_b_i];
    end
  end
endmodule

// ---- src/pllsc_top.sv ----
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pllsc_defines.svh"
module pllsc_top import pllsc_pkg::*; #(
  parameter int TMO_W = 16
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_B_I,
  input  wire logic        SCLK_I,
  input  wire logic        SDATA_I,
  input  wire logic        LOAD_STROBE_I,
  input  wire logic        CE_I,
  input  wire logic        PD_TICK_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [2:0]       PUMP_CURRENT_O,
  output logic             PUMP_OUTPUT_EN_O,
  output logic             COUNTER_LOAD_O,
  output logic             RESET_PULSE_O,
  output logic             POWER_DOWN_O,
  output logic             FAST_ACTIVE_O
);
  // ==========================================================
  // Reset release and pin synchronisers
  logic        rst_s1_reg;
  logic        rst_n;
  pllsc_pins_t pins_s1_reg;
  pllsc_pins_t pins_s2_reg;
  pllsc_pins_t pins_s3_reg;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      pins_s3_reg <= '0;
    end else begin
      pins_s1_reg <= {CE_I, LOAD_STROBE_I, SDATA_I, SCLK_I};
      pins_s2_reg <= pins_s1_reg;
      pins_s3_reg <= pins_s2_reg;
    end
  end
  // ==========================================================
  // Latch fields
  logic [23:0]      shift_reg, shift_next, ref_reg, ref_next;
  logic [23:0]      div_reg, div_next, func_reg, func_next;
  logic [23:0]      init_reg, init_next;
  logic             armed_reg, armed_next, pulse_reg, pulse_next;
  logic             spd_reg, spd_next;
  logic [TMO_W-1:0] cnt_reg, cnt_next, lut_q, lut_bq;
  logic             sclk_rise, le_rise, ce, fl_en, fl_mode, fast_sel;
  logic             crst, pd_req, pd_sync_sel, tristate, power_down;
  logic             hold, timer_on, tmo_hit;
  logic [3:0]       tmo_code;
  logic [2:0]       cpi_pri, cpi_sec;
  assign sclk_rise   = pins_s2_reg.sclk & ~pins_s3_reg.sclk;
  assign le_rise     = pins_s2_reg.le & ~pins_s3_reg.le;
  assign ce          = pins_s2_reg.ce;
  assign fl_en       = func_reg[`PLLSC_FL_EN_BIT];
  assign fl_mode     = func_reg[`PLLSC_FL_MODE_BIT];
  assign tmo_code    = func_reg[`PLLSC_TMO_LSB +: 4];
  assign cpi_pri     = func_reg[`PLLSC_CPI_PRI_LSB +: 3];
  assign cpi_sec     = func_reg[`PLLSC_CPI_SEC_LSB +: 3];
  assign crst        = func_reg[`PLLSC_CNT_RST_BIT];
  assign pd_req      = func_reg[`PLLSC_PD_REQ_BIT];
  assign pd_sync_sel = func_reg[`PLLSC_PD_SYNC_BIT];
  assign tristate    = func_reg[`PLLSC_TRISTATE_BIT];
  assign fast_sel    = div_reg[`PLLSC_FAST_SEL_BIT];
  // Chip enable low forces power-down regardless of latches
  assign power_down  = ~ce | (pd_req & pd_sync_sel) | spd_reg;
  assign hold        = power_down | crst | pulse_reg;
  assign timer_on    = fl_en & fl_mode & fast_sel & ~hold;
  assign tmo_hit     = timer_on & PD_TICK_I &
                       ((cnt_reg + TMO_W'(1)) >= lut_q);
  // ==========================================================
  // Serial shift, latch routing and fastlock timer
  always_comb begin
    shift_next = shift_reg;
    ref_next   = ref_reg;
    div_next   = div_reg;
    func_next  = func_reg;
    init_next  = init_reg;
    armed_next = armed_reg;
    pulse_next = 1'b0;
    cnt_next   = cnt_reg;
    spd_next   = spd_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[22:0], pins_s2_reg.sdata};
    end
    if (!timer_on) begin
      cnt_next = '0;
    end else if (PD_TICK_I) begin
      if (tmo_hit) begin
        cnt_next = '0;
        div_next[`PLLSC_FAST_SEL_BIT] = 1'b0;
      end else begin
        cnt_next = cnt_reg + TMO_W'(1);
      end
    end
    // A new divider word wins over the timer clearing fast select
    if (le_rise) begin
      case (shift_reg[1:0])
        `PLLSC_SEL_REF: begin
          ref_next = shift_reg;
        end
        `PLLSC_SEL_DIV: begin
          div_next = shift_reg;
          if (armed_reg) begin
            pulse_next = 1'b1;
            armed_next = 1'b0;
          end
        end
        `PLLSC_SEL_FUNC: begin
          func_next = shift_reg;
        end
        default: begin
          init_next  = shift_reg;
          func_next  = shift_reg;
          pulse_next = 1'b1;
          armed_next = 1'b1;
        end
      endcase
    end
    if (!(pd_req & ~pd_sync_sel)) begin
      spd_next = 1'b0;
    end else if ((pulse_reg | PD_TICK_I) & ~crst & ce) begin
      spd_next = 1'b1;
    end
  end
  // Latches are reset only by the system reset, never by CE
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `PLLSC_LATCH_RST;
      ref_reg   <= `PLLSC_LATCH_RST;
      div_reg   <= `PLLSC_LATCH_RST;
      func_reg  <= `PLLSC_LATCH_RST;
      init_reg  <= `PLLSC_LATCH_RST;
      armed_reg <= 1'b0;
      pulse_reg <= 1'b0;
      cnt_reg   <= '0;
      spd_reg   <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      ref_reg   <= ref_next;
      div_reg   <= div_next;
      func_reg  <= func_next;
      init_reg  <= init_next;
      armed_reg <= armed_next;
      pulse_reg <= pulse_next;
      cnt_reg   <= cnt_next;
      spd_reg   <= spd_next;
    end
  end
  // ==========================================================
  // Analog control outputs
  pllsc_stat_t stat_reg, stat_next;
  always_comb begin
    stat_next              = stat_reg;
    stat_next.init_armed   = armed_reg;
    stat_next.fast_active  = fl_en & fast_sel;
    stat_next.power_down   = power_down;
    stat_next.counter_load = hold;
    stat_next.pump_enable  = ~hold & ~tristate;
    stat_next.pump_current = (fl_en & fast_sel) ? cpi_sec
                                                : cpi_pri;
  end
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end
  assign PUMP_CURRENT_O   = stat_reg.pump_current;
  assign PUMP_OUTPUT_EN_O = stat_reg.pump_enable;
  assign COUNTER_LOAD_O   = stat_reg.counter_load;
  assign POWER_DOWN_O     = stat_reg.power_down;
  assign FAST_ACTIVE_O    = stat_reg.fast_active;
  assign RESET_PULSE_O    = pulse_reg;
  // ==========================================================
  // Register bus
  function automatic logic is_lut(input logic [7:0] a);
    return a[7:6] == 2'(`PLLSC_ADDR_LUT >> 6);
  endfunction
  logic        bvalid_reg, bvalid_next, wtake, lut_we;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  pllsc_rd_t   rst_reg, rst_next;
  logic [7:0]  raddr_reg, raddr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [3:0]  lut_raddr;
  assign wtake     = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~bvalid_reg;
  assign lut_we    = wtake & is_lut(S_AXI_AWADDR_I) &
                     (S_AXI_WSTRB_I[1:0] == 2'h3);
  assign lut_raddr = (rst_reg == RD_IDLE) ? S_AXI_ARADDR_I[5:2]
                                          : raddr_reg[5:2];
  pllsc_tmo_table #(.DW(TMO_W), .AW(4)) u_table (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (rst_n),
    .we_i      (lut_we),
    .waddr_i   (S_AXI_AWADDR_I[5:2]),
    .wdata_i   (S_AXI_WDATA_I[TMO_W-1:0]),
    .raddr_a_i (tmo_code),
    .rdata_a_o (lut_q),
    .raddr_b_i (lut_raddr),
    .rdata_b_o (lut_bq)
  );
  always_comb begin
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rst_next    = rst_reg;
    raddr_next  = raddr_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (wtake) begin
      bvalid_next = 1'b1;
      bresp_next  = is_lut(S_AXI_AWADDR_I) ? `PLLSC_RESP_OKAY
                                           : `PLLSC_RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_next = 1'b0;
    end
    case (rst_reg)
      RD_IDLE: begin
        if (S_AXI_ARVALID_I) begin
          raddr_next = S_AXI_ARADDR_I;
          rst_next   = RD_DATA;
        end
      end
      RD_DATA: begin
        rresp_next = `PLLSC_RESP_OKAY;
        rdata_next = 32'h00000000;
        if (is_lut(raddr_reg)) begin
          rdata_next[TMO_W-1:0] = lut_bq;
        end else begin
          case (raddr_reg)
            `PLLSC_ADDR_REF:  rdata_next[23:0] = ref_reg;
            `PLLSC_ADDR_DIV:  rdata_next[23:0] = div_reg;
            `PLLSC_ADDR_FUNC: rdata_next[23:0] = func_reg;
            `PLLSC_ADDR_INIT: rdata_next[23:0] = init_reg;
            `PLLSC_ADDR_STAT: rdata_next[7:0]  = stat_reg;
            default:          rresp_next = `PLLSC_RESP_SLVERR;
          endcase
        end
        rst_next = RD_RESP;
      end
      RD_RESP: begin
        if (S_AXI_RREADY_I) begin
          rst_next = RD_IDLE;
        end
      end
      default: rst_next = RD_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `PLLSC_RESP_OKAY;
      rst_reg    <= RD_IDLE;
      raddr_reg  <= 8'h00;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `PLLSC_RESP_OKAY;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rst_reg    <= rst_next;
      raddr_reg  <= raddr_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end
  assign S_AXI_AWREADY_O = wtake;
  assign S_AXI_WREADY_O  = wtake;
  assign S_AXI_BVALID_O  = bvalid_reg;
  assign S_AXI_BRESP_O   = bresp_reg;
  assign S_AXI_ARREADY_O = (rst_reg == RD_IDLE);
  assign S_AXI_RVALID_O  = (rst_reg == RD_RESP);
  assign S_AXI_RDATA_O   = rdata_reg;
  assign S_AXI_RRESP_O   = rresp_reg;
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);
  sequence seq_load(logic [1:0] s);
    le_rise && shift_reg[1:0] == s;
  endsequence
  sequence seq_init_then_div;
    seq_load(`PLLSC_SEL_INIT) ##1 (!le_rise) [*1] ##[1:300]
      seq_load(`PLLSC_SEL_DIV);
  endsequence
  chk_fast_current: assert property (
    fl_en && fast_sel && !le_rise |=> PUMP_CURRENT_O == $past(cpi_sec))
    else $error("fast select did not pick second current");
  chk_timer_clear: assert property (
    tmo_hit && !le_rise |=> !fast_sel ##1 PUMP_CURRENT_O == cpi_pri)
    else $error("timeout did not clear fast select");
  chk_timer_idle: assert property (
    !(fl_en && fl_mode) |=> cnt_reg == '0)
    else $error("timer ran outside timer mode");
  chk_tristate_pump: assert property (
    tristate |=> !PUMP_OUTPUT_EN_O)
    else $error("pump driven while three-state set");
  chk_init_pulse: assert property (
    seq_load(`PLLSC_SEL_INIT) |=>
      RESET_PULSE_O && func_reg == init_reg ##1 !RESET_PULSE_O)
    else $error("init load missed pulse or function copy");
  chk_first_div_pulse: assert property (
    seq_init_then_div |=> RESET_PULSE_O == $past(armed_reg))
    else $error("divider pulse after init wrong");
  chk_route_ref: assert property (
    seq_load(`PLLSC_SEL_REF) |=> ref_reg == $past(shift_reg))
    else $error("reference latch not loaded");
  chk_ce_powerdown: assert property (
    !ce |=> POWER_DOWN_O && COUNTER_LOAD_O)
    else $error("chip enable low did not power down");
  chk_ce_keeps_latch: assert property (
    !ce && !le_rise && !tmo_hit |=> $stable(div_reg) && $stable(func_reg))
    else $error("latch changed in power-down");
  chk_crst_hold: assert property (
    crst |=> COUNTER_LOAD_O && !PUMP_OUTPUT_EN_O && !spd_reg)
    else $error("counter reset did not hold");
  chk_sync_pd: assert property (
    pulse_reg && ce && pd_req && !pd_sync_sel && !crst
      |=> spd_reg ##1 POWER_DOWN_O)
    else $error("init pulse did not trigger power-down");
  chk_shift_in: assert property (
    sclk_rise |=> shift_reg[0] == $past(pins_s2_reg.sdata))
    else $error("serial bit not shifted");
endmodule

// ---- test/pllsc_host_model.sv ----
`timescale 1ns/10ps
module pllsc_host_model (
  output logic sclk_o,
  output logic sdata_o,
  output logic strobe_o
);
  // ==========================================================
  // Serial master, clock idles low between frames
  initial begin
    sclk_o = 1'h0;
    sdata_o = 1'h1;
    strobe_o = 1'h0;
  end
  // ==========================================================
  // One word: three bytes MSB first, then strobe pulse
  task automatic send_word(input logic [23:0] w);
    strobe_o = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      sdata_o = w[i];
      #62.5 sclk_o = 1'h1;
      #62.5 sclk_o = 1'h0;
    end
    sdata_o = ~w[0];
    #62.5 strobe_o = 1'h1;
    #62.5 strobe_o = 1'h0;
  endtask
endmodule

// ---- test/pllsc_top_tb.sv ----
`timescale 1ns/10ps
`include "pllsc_defines.svh"
module pllsc_top_tb;
  // ==========================================================
  // Signals
  logic        clk = 1'h0, rst_b = 1'h0, ce = 1'h1, tick = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, seed = 32'h18;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pen, cload, rpulse, pdown, fast, sclk, sdata, strobe;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pcur;
  logic [23:0] lat [4] = '{default: 24'h0};
  int          err_count, n_compared, n_pulse, exp_p, armed;
  // Prescaler select left at a legal setting for the input in use
  localparam logic [23:0] FB = {3'h0, 3'h2, 3'h5, 4'h2, 11'h602};

  pllsc_top uut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .SCLK_I(sclk), .SDATA_I(sdata),
    .LOAD_STROBE_I(strobe), .CE_I(ce), .PD_TICK_I(tick),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .PUMP_CURRENT_O(pcur),
    .PUMP_OUTPUT_EN_O(pen), .COUNTER_LOAD_O(cload),
    .RESET_PULSE_O(rpulse), .POWER_DOWN_O(pdown), .FAST_ACTIVE_O(fast)
  );
  pllsc_host_model host (.sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe));

  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (rpulse === 1'h1) n_pulse++;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
    cmp(32'(bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er, input logic [31:0] m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
    cmp(rdata & m, ed & m);
    cmp(32'(rresp), 32'(er));
  endtask
  task automatic send(input logic [23:0] w);
    host.send_word(w);
    lat[w[1:0]] = w;
    if (w[1:0] == 2'h3) lat[2] = w;
    if (w[1:0] == 2'h1 && armed != 0) exp_p++;
    if (w[1:0] == 2'h1) armed = 0;
    if (w[1:0] == 2'h3) exp_p++;
    if (w[1:0] == 2'h3) armed = 1;
    repeat (8) @(posedge clk);
    cmp(32'(n_pulse), 32'(exp_p));
  endtask
  task automatic chk_lat();
    for (int i = 0; i < 4; i++) begin
      axi_rd(8'(4 * i), 32'(lat[i]), `PLLSC_RESP_OKAY, 32'hFFFFFC);
    end
  endtask
  task automatic outs(input logic [6:0] e);
    cmp(32'({pcur, pen, cload, pdown, fast}), 32'(e));
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) tick <= 1'h1;
      @(posedge clk) tick <= 1'h0;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #500000;
    err_count++;
    test_done();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      axi_rd(8'h40 + 8'(4 * i), 32'(3 + 4 * i), 2'h0, 32'hFFFF);
    end
    axi_rd(8'h20, 32'h0, `PLLSC_RESP_SLVERR, 32'hFFFFFFFF);
    axi_wr(`PLLSC_ADDR_REF, 32'h1, `PLLSC_RESP_SLVERR);
    $display("test registers done");
    send(FB | 24'h1);
    send(FB);
    send(24'(xs() & 32'hFFFFFC));
    send(24'(xs() & 32'hDFFFFC) | 24'h1);
    send(24'(xs() & 32'hDFFFFC) | 24'h1);
    chk_lat();
    outs(7'h58);
    $display("test routing done");
    axi_wr(8'h48, 32'h4, `PLLSC_RESP_OKAY);
    send(lat[1] | 24'h200000);
    outs(7'h29);
    ticks(3);
    outs(7'h29);
    ticks(1);
    outs(7'h58);
    lat[1][21] = 1'h0;
    chk_lat();
    send(FB & ~24'h400);
    send(lat[1] | 24'h200000);
    ticks(6);
    outs(7'h29);
    send(FB & ~24'h600);
    outs(7'h58);
    send(lat[1] & ~24'h200000);
    send(FB);
    $display("test fastlock done");
    send(FB | 24'h100);
    outs(7'h50);
    send(FB);
    outs(7'h58);
    send(FB | 24'hC);
    outs(7'h54);
    ticks(2);
    outs(7'h54);
    send(lat[0]);
    send(lat[1]);
    send(FB);
    outs(7'h58);
    $display("test counter reset done");
    @(posedge clk) ce <= 1'h0;
    repeat (6) @(posedge clk);
    outs(7'h56);
    chk_lat();
    @(posedge clk) ce <= 1'h1;
    repeat (125) @(posedge clk);
    outs(7'h58);
    chk_lat();
    $display("test chip enable done");
    send(FB | 24'h9);
    outs(7'h56);
    chk_lat();
    $display("test init power-down done");
    test_done();
  end
endmodule
